// *** oam_addr_unit.sv ***
// operand address mode unit: decodes a gen field and forms the operand address
`timescale 1ns/1ns
`include "oam_defs.svh"

module oam_addr_unit #(
    parameter int ADDR_W = `OAM_ADDR_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [4:0] mode_gen,
    input wire logic [7:0] index_byte,
    input wire logic [31:0] disp1_raw,
    input wire logic [31:0] disp2_raw,
    input wire logic [31:0] imm_value,
    input wire logic op_write,
    input wire logic aux_bank,
    input wire logic [3:0] op_size,
    input wire logic [7:0][31:0] general_register,
    input wire logic [31:0] program_counter,
    input wire logic [31:0] stack_pointer_zero,
    input wire logic [31:0] stack_pointer_one,
    input wire logic [31:0] static_base,
    input wire logic [31:0] frame_pointer,
    input wire logic [31:0] link_table_base,
    input wire logic stack_select,
    input wire logic mem_rd_ack,
    input wire logic [31:0] mem_rd_data,
    output oam_pkg::oam_state_type unit_state_ff,
    output logic mem_rd_req_ff,
    output logic [ADDR_W-1:0] mem_rd_addr_ff,
    output logic done_ff,
    output logic illegal_ff,
    output logic ea_valid_ff,
    output logic [ADDR_W-1:0] ea_ff,
    output logic reg_sel_ff,
    output logic reg_aux_ff,
    output logic [2:0] reg_num_ff,
    output logic imm_sel_ff,
    output logic [31:0] imm_data_ff,
    output logic sp_upd_ff,
    output logic sp_which_ff,
    output logic [31:0] sp_new_ff,
    output logic [2:0] disp1_len_ff,
    output logic [2:0] disp2_len_ff
);
    import oam_pkg::*;

    // ----------------------------------------------------------------
    // displacement decode
    // ----------------------------------------------------------------
    logic [31:0] disp1_val;
    logic [31:0] disp2_val;
    logic [2:0] disp1_len;
    logic [2:0] disp2_len;

    oam_disp_decode u_disp1 (
        .disp_raw(disp1_raw),
        .disp_value(disp1_val),
        .disp_len(disp1_len)
    );

    oam_disp_decode u_disp2 (
        .disp_raw(disp2_raw),
        .disp_value(disp2_val),
        .disp_len(disp2_len)
    );

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    wire scaled = mode_gen[4:2] == `OAM_M_IDX_HI;
    wire [4:0] base_mode = scaled ? index_byte[7:3] : mode_gen;
    wire [2:0] idx_reg = index_byte[2:0];
    wire [1:0] idx_scale = mode_gen[1:0];
    wire is_reg = base_mode[4:3] == `OAM_M_REG_HI;
    wire is_rrel = base_mode[4:3] == `OAM_M_RREL_HI;
    wire is_mrel = (base_mode[4:2] == `OAM_M_MREL_HI) && (base_mode != `OAM_M_RSVD);
    wire is_rsvd = base_mode == `OAM_M_RSVD;
    wire is_imm = base_mode == `OAM_M_IMM;
    wire is_abs = base_mode == `OAM_M_ABS;
    wire is_ext = base_mode == `OAM_M_EXT;
    wire is_tos = base_mode == `OAM_M_TOS;
    wire is_mspace = base_mode[4:2] == `OAM_M_MSPACE_HI;
    wire nested_idx = scaled && (base_mode[4:2] == `OAM_M_IDX_HI);
    wire needs_ptr = is_mrel || is_ext;

    // reserved code, immediate write, immediate or nested under index
    wire illegal = is_rsvd || (is_imm && (op_write || scaled)) || nested_idx;
    wire start_ok = start && (unit_state_ff == OAM_IDLE);

    // ----------------------------------------------------------------
    // base registers
    // ----------------------------------------------------------------
    wire [31:0] sel_sp = stack_select ? stack_pointer_one : stack_pointer_zero;
    // low two bits order fp, sp, sb, pc for memory space; memory relative uses only fp, sp, sb (its fourth code is reserved)
    wire [31:0] mspace_base = base_mode[1] ?
                              (base_mode[0] ? program_counter : static_base) :
                              (base_mode[0] ? sel_sp : frame_pointer);
    wire [31:0] rrel_base = general_register[base_mode[2:0]];
    wire [31:0] idx_term = scaled ? (general_register[idx_reg] << idx_scale) : 32'h00000000;

    // ----------------------------------------------------------------
    // top of stack: push pre-decrements, pop post-increments
    // ----------------------------------------------------------------
    wire [31:0] size_ext = {28'h0000000, op_size};
    wire [31:0] sp_push = sel_sp - size_ext;
    wire [31:0] sp_pop = sel_sp + size_ext;
    wire [31:0] tos_addr = op_write ? sp_push : sel_sp;
    wire [31:0] tos_new = op_write ? sp_push : sp_pop;

    // ----------------------------------------------------------------
    // address sums, full 32 bits then cut to the physical width
    // ----------------------------------------------------------------
    wire [31:0] rrel_sum = rrel_base + disp1_val;
    wire [31:0] mspace_sum = mspace_base + disp1_val;
    wire [31:0] direct_sum = is_rrel ? rrel_sum :
                             is_mspace ? mspace_sum :
                             is_abs ? disp1_val :
                             is_tos ? tos_addr : 32'h00000000;
    wire [31:0] direct_full = direct_sum + idx_term;
    wire [ADDR_W-1:0] direct_ea = direct_full[ADDR_W-1:0];
    wire [ADDR_W-1:0] disp1_ea = disp1_val[ADDR_W-1:0];
    wire [ADDR_W-1:0] rrel_ea = rrel_sum[ADDR_W-1:0];
    // link table entries are one double word each
    wire [31:0] link_addr = link_table_base + (disp1_val << `OAM_LINK_SHIFT);
    wire [31:0] ptr_full = is_ext ? link_addr : mspace_sum;
    wire [ADDR_W-1:0] ptr_addr = ptr_full[ADDR_W-1:0];

    // pointer result uses the second displacement and index held from start
    logic [31:0] disp2_hold_ff;
    logic [31:0] idx_hold_ff;
    wire [31:0] ptr_sum = mem_rd_data + disp2_hold_ff + idx_hold_ff;
    wire [ADDR_W-1:0] ptr_ea = ptr_sum[ADDR_W-1:0];
    wire ptr_taken = (unit_state_ff == OAM_PTR_WAIT) && mem_rd_ack;

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    oam_state_type nxt_state;

    always_comb begin
        case (unit_state_ff)
            OAM_IDLE: nxt_state = !start_ok ? OAM_IDLE :
                                  ((needs_ptr && !illegal) ? OAM_PTR_REQ : OAM_DONE);
            OAM_PTR_REQ: nxt_state = OAM_PTR_WAIT;
            OAM_PTR_WAIT: nxt_state = mem_rd_ack ? OAM_DONE : OAM_PTR_WAIT;
            OAM_DONE: nxt_state = OAM_IDLE;
            default: nxt_state = OAM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            unit_state_ff <= OAM_IDLE;
        end else begin
            unit_state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // pointer read port, request held until acknowledged
    // ----------------------------------------------------------------
    wire nxt_rd_req = (start_ok && needs_ptr && !illegal) || (mem_rd_req_ff && !mem_rd_ack);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mem_rd_req_ff <= 1'b0;
            mem_rd_addr_ff <= `OAM_ADDR_RST;
        end else begin
            mem_rd_req_ff <= nxt_rd_req;
            if (start_ok) begin
                mem_rd_addr_ff <= ptr_addr;
            end
        end
    end

    // sampled when start is accepted, so later register changes do not leak in
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            disp2_hold_ff <= `OAM_WORD_RST;
            idx_hold_ff <= `OAM_WORD_RST;
        end else if (start_ok) begin
            disp2_hold_ff <= disp2_val;
            idx_hold_ff <= idx_term;
        end
    end

    // ----------------------------------------------------------------
    // completion and result outputs
    // ----------------------------------------------------------------
    wire direct_done = start_ok && !(needs_ptr && !illegal);
    wire nxt_done = direct_done || ptr_taken;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
            ea_valid_ff <= 1'b0;
            ea_ff <= `OAM_ADDR_RST;
        end else begin
            done_ff <= nxt_done;
            if (direct_done) begin
                illegal_ff <= illegal;
                ea_valid_ff <= !illegal && !is_reg && !is_imm;
                ea_ff <= direct_ea;
            end else if (ptr_taken) begin
                illegal_ff <= 1'b0;
                ea_valid_ff <= 1'b1;
                ea_ff <= ptr_ea;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_sel_ff <= 1'b0;
            reg_aux_ff <= 1'b0;
            reg_num_ff <= 3'h0;
            imm_sel_ff <= 1'b0;
            imm_data_ff <= `OAM_WORD_RST;
        end else if (start_ok) begin
            reg_sel_ff <= is_reg && !scaled;
            reg_aux_ff <= is_reg && !scaled && aux_bank;
            reg_num_ff <= base_mode[2:0];
            imm_sel_ff <= is_imm && !illegal;
            imm_data_ff <= imm_value;
        end
    end

    // stack pointer write-back only for a legal top-of-stack operand
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sp_upd_ff <= 1'b0;
            sp_which_ff <= 1'b0;
            sp_new_ff <= `OAM_WORD_RST;
        end else begin
            sp_upd_ff <= direct_done && is_tos && !illegal;
            if (start_ok) begin
                sp_which_ff <= stack_select;
                sp_new_ff <= tos_new;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            disp1_len_ff <= 3'h0;
            disp2_len_ff <= 3'h0;
        end else if (start_ok) begin
            disp1_len_ff <= disp1_len;
            disp2_len_ff <= disp2_len;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    reg_direct_a: assert property (
        start_ok && is_reg && !scaled |=> done_ff && reg_sel_ff && !ea_valid_ff && !mem_rd_req_ff)
        else $error("register mode made an address or access");

    rrel_sum_a: assert property (
        start_ok && is_rrel && !scaled && !illegal |=> ea_ff == $past(rrel_ea))
        else $error("register relative address wrong");

    abs_addr_a: assert property (
        start_ok && is_abs && !scaled |=> ea_valid_ff && ea_ff == $past(disp1_ea))
        else $error("absolute address differs from displacement");

    ptr_request_a: assert property (
        start_ok && needs_ptr && !illegal |=> mem_rd_req_ff && mem_rd_addr_ff == $past(ptr_addr))
        else $error("pointer read not issued at the right address");

    ptr_finish_a: assert property (
        mem_rd_req_ff && mem_rd_ack |=> !mem_rd_req_ff ##0 done_ff ##0 ea_valid_ff)
        else $error("pointer answer did not finish the operand");

    rsvd_flag_a: assert property (
        start_ok && is_rsvd |=> done_ff && illegal_ff && !ea_valid_ff)
        else $error("reserved mode not flagged");

    imm_write_a: assert property (
        start_ok && is_imm && op_write |=> illegal_ff && !imm_sel_ff)
        else $error("immediate written without flag");

    tos_push_a: assert property (
        start_ok && is_tos && op_write && !scaled |=> sp_upd_ff && ea_ff == sp_new_ff[ADDR_W-1:0])
        else $error("push address not the new stack pointer");

    done_pulse_a: assert property (
        done_ff |=> !done_ff && (unit_state_ff == OAM_IDLE))
        else $error("completion pulse longer than one cycle");

    reg_path_c: cover property (start_ok && is_reg ##1 done_ff);
    ptr_path_c: cover property (start_ok && is_mrel ##[1:20] ptr_taken);
    ext_path_c: cover property (start_ok && is_ext ##[1:20] ptr_taken);
    tos_pop_c: cover property (start_ok && is_tos && !op_write ##1 sp_upd_ff);
    idx_path_c: cover property (start_ok && scaled && !illegal ##1 done_ff);

endmodule // oam_addr_unit

// *** oam_defs.svh ***
// constants for the operand address mode unit
`ifndef OAM_DEFS_SVH
`define OAM_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define OAM_ADDR_W 24
`define OAM_DATA_W 32

// ----------------------------------------------------------------
// general addressing mode codes
// ----------------------------------------------------------------
`define OAM_M_MREL_FP 5'h10
`define OAM_M_RSVD 5'h13
`define OAM_M_IMM 5'h14
`define OAM_M_ABS 5'h15
`define OAM_M_EXT 5'h16
`define OAM_M_TOS 5'h17
`define OAM_M_IDX_HI 3'h7
`define OAM_M_MSPACE_HI 3'h6
`define OAM_M_MREL_HI 3'h4
`define OAM_M_REG_HI 2'h0
`define OAM_M_RREL_HI 2'h1

// ----------------------------------------------------------------
// displacement encoding and link table layout
// ----------------------------------------------------------------
`define OAM_DISP_LEN_1 3'h1
`define OAM_DISP_LEN_2 3'h2
`define OAM_DISP_LEN_4 3'h4
`define OAM_DISP_TAG_2 2'h2
`define OAM_LINK_SHIFT 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OAM_ADDR_RST 24'h000000
`define OAM_WORD_RST 32'h00000000

`endif

// *** oam_pkg.sv ***
// types for the operand address mode unit
package oam_pkg;

    // gray coded along idle, request, wait, done
    typedef enum logic [1:0] {
        OAM_IDLE = 2'b00,
        OAM_PTR_REQ = 2'b01,
        OAM_PTR_WAIT = 2'b11,
        OAM_DONE = 2'b10
    } oam_state_type;

endpackage

// *** oam_disp_decode.sv ***
// displacement length and sign decoder
`timescale 1ns/1ns
`include "oam_defs.svh"

module oam_disp_decode (
    input wire logic [31:0] disp_raw,
    output logic [31:0] disp_value,
    output logic [2:0] disp_len
);
    // ----------------------------------------------------------------
    // length from the top bits of the first byte, msb first
    // ----------------------------------------------------------------
    wire is_one = ~disp_raw[31];
    wire is_two = disp_raw[31:30] == `OAM_DISP_TAG_2;
    wire [31:0] val_one = {{25{disp_raw[30]}}, disp_raw[30:24]};
    wire [31:0] val_two = {{18{disp_raw[29]}}, disp_raw[29:16]};
    wire [31:0] val_four = {{2{disp_raw[29]}}, disp_raw[29:0]};

    assign disp_value = is_one ? val_one : (is_two ? val_two : val_four);
    assign disp_len = is_one ? `OAM_DISP_LEN_1 :
                      (is_two ? `OAM_DISP_LEN_2 : `OAM_DISP_LEN_4);

endmodule // oam_disp_decode

// *** oam_mem_model.sv ***
// memory access unit model answering pointer reads
`timescale 1ns/1ns

module oam_mem_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] wait_cycles,
    input wire logic mem_rd_req_ff,
    input wire logic [23:0] mem_rd_addr_ff,
    output logic mem_rd_ack,
    output logic [31:0] mem_rd_data,
    output int read_count
);
    logic [3:0] wait_ff;

    // data is only meaningful with ack; otherwise it toggles so stale values never match
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mem_rd_ack <= 1'b0;
            mem_rd_data <= 32'h00000000;
            wait_ff <= 4'h0;
            read_count <= 0;
        end else if (mem_rd_ack) begin
            mem_rd_ack <= 1'b0;
            mem_rd_data <= ~mem_rd_data;
        end else if (mem_rd_req_ff && wait_ff == wait_cycles) begin
            mem_rd_ack <= 1'b1;
            mem_rd_data <= {8'hA5, mem_rd_addr_ff ^ 24'h00F00F};
            read_count <= read_count + 1;
            wait_ff <= 4'h0;
        end else begin
            wait_ff <= mem_rd_req_ff ? wait_ff + 4'h1 : 4'h0;
            mem_rd_data <= ~mem_rd_data;
        end
    end
endmodule // oam_mem_model

// *** operand_address_mode_unit_bench.sv ***
// self-checking bench for the operand address mode unit
`timescale 1ns/1ns

module operand_address_mode_unit_bench;
    import oam_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic [4:0] mode_gen = 5'h00;
    logic [7:0] index_byte = 8'h00;
    logic [31:0] disp1_raw = 32'h0;
    logic [31:0] disp2_raw = 32'h0;
    logic [31:0] imm_value = 32'h12345678;
    logic op_write = 1'b0;
    logic aux_bank = 1'b0;
    logic [3:0] op_size = 4'h4;
    logic [7:0][31:0] gr;
    logic [31:0] pc = 32'h00400100;
    logic [31:0] sp0 = 32'h00800000;
    logic [31:0] sp1 = 32'h00900000;
    logic [31:0] sb = 32'h00A00000;
    logic [31:0] fp = 32'h00B00000;
    logic [31:0] ltb = 32'h00C00000;
    logic stack_select = 1'b0;
    logic [3:0] wait_n = 4'h0;
    logic mem_rd_ack;
    logic [31:0] mem_rd_data;
    int read_count;
    oam_state_type unit_state_ff;
    logic mem_rd_req_ff, done_ff, illegal_ff, ea_valid_ff;
    logic reg_sel_ff, reg_aux_ff, imm_sel_ff, sp_upd_ff, sp_which_ff;
    logic [23:0] mem_rd_addr_ff, ea_ff;
    logic [2:0] reg_num_ff, disp1_len_ff, disp2_len_ff;
    logic [31:0] imm_data_ff, sp_new_ff;
    int miscompares = 0;
    int check_count = 0;

    oam_addr_unit dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .start(start),
        .mode_gen(mode_gen), .index_byte(index_byte), .disp1_raw(disp1_raw),
        .disp2_raw(disp2_raw), .imm_value(imm_value), .op_write(op_write),
        .aux_bank(aux_bank), .op_size(op_size), .general_register(gr),
        .program_counter(pc), .stack_pointer_zero(sp0), .stack_pointer_one(sp1),
        .static_base(sb), .frame_pointer(fp), .link_table_base(ltb),
        .stack_select(stack_select), .mem_rd_ack(mem_rd_ack),
        .mem_rd_data(mem_rd_data), .unit_state_ff(unit_state_ff),
        .mem_rd_req_ff(mem_rd_req_ff), .mem_rd_addr_ff(mem_rd_addr_ff),
        .done_ff(done_ff), .illegal_ff(illegal_ff), .ea_valid_ff(ea_valid_ff),
        .ea_ff(ea_ff), .reg_sel_ff(reg_sel_ff), .reg_aux_ff(reg_aux_ff),
        .reg_num_ff(reg_num_ff), .imm_sel_ff(imm_sel_ff), .imm_data_ff(imm_data_ff),
        .sp_upd_ff(sp_upd_ff), .sp_which_ff(sp_which_ff), .sp_new_ff(sp_new_ff),
        .disp1_len_ff(disp1_len_ff), .disp2_len_ff(disp2_len_ff));

    oam_mem_model mem_u (.clk_sys(clk_sys), .rst_n(rst_n), .wait_cycles(wait_n),
        .mem_rd_req_ff(mem_rd_req_ff), .mem_rd_addr_ff(mem_rd_addr_ff),
        .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .read_count(read_count));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] ptr(input logic [31:0] a);
        return {8'hA5, a[23:0] ^ 24'h00F00F};
    endfunction

    task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_f(input logic got, input logic exp, input string what);
        cmp_v({31'h0, got}, {31'h0, exp}, what);
    endtask

    task automatic chk_ea(input logic [31:0] exp);
        cmp_f(ea_valid_ff, 1'b1, "ea valid");
        cmp_v({8'h00, ea_ff}, exp & 32'h00FFFFFF, "ea");
    endtask

    // waits for done; direct modes must make no read, pointer modes exactly one
    task automatic op(input logic [4:0] m, input logic [7:0] ib, input logic [31:0] d1,
                      input logic [31:0] d2, input logic wr, input int reads);
        int c0;
        int n;
        c0 = read_count;
        @(negedge clk_sys);
        mode_gen = m;
        index_byte = ib;
        disp1_raw = d1;
        disp2_raw = d2;
        op_write = wr;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        n = 0;
        while (done_ff !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        cmp_f(done_ff, 1'b1, "done");
        cmp_v(32'(read_count - c0), 32'(reads), "reads");
        cmp_v({30'h0, unit_state_ff}, {30'h0, OAM_DONE}, "state");
        cmp_f(mem_rd_req_ff, 1'b0, "req dropped");
    endtask

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reg();
        for (int i = 0; i < 8; i++) begin
            aux_bank = i[0];
            op(5'(i), 8'h00, 32'h0, 32'h0, 1'b0, 0);
            cmp_f(reg_sel_ff, 1'b1, "reg sel");
            cmp_v({29'h0, reg_num_ff}, 32'(i), "reg num");
            cmp_f(reg_aux_ff, i[0], "aux bank");
            cmp_f(ea_valid_ff, 1'b0, "no ea");
        end
        aux_bank = 1'b0;
    endtask

    task automatic t_rrel();
        logic [31:0] d;
        for (int i = 0; i < 8; i++) begin
            d = i[0] ? 32'h92340000 : 32'h7F000000;
            op(5'h08 + 5'(i), 8'h00, d, 32'h0, 1'b0, 0);
            chk_ea(gr[i] + (i[0] ? 32'h00001234 : 32'hFFFFFFFF));
            cmp_v({29'h0, disp1_len_ff}, i[0] ? 32'd2 : 32'd1, "disp1 len");
        end
        gr[3] = gr[3] + 32'h100;
        op(5'h0B, 8'h00, 32'h7F000000, 32'h0, 1'b0, 0);
        chk_ea(gr[3] - 32'h1);
    endtask

    task automatic t_mspace();
        logic [31:0] b;
        for (int s = 0; s < 2; s++) begin
            stack_select = s[0];
            for (int k = 0; k < 4; k++) begin
                b = (k == 0) ? fp : (k == 1) ? (s[0] ? sp1 : sp0) : (k == 2) ? sb : pc;
                op(5'h18 + 5'(k), 8'h00, 32'hC0001000, 32'h0, 1'b0, 0);
                chk_ea(b + 32'h1000);
                cmp_v({29'h0, disp1_len_ff}, 32'd4, "disp1 len");
            end
        end
    endtask

    task automatic t_mrel();
        logic [31:0] b;
        for (int k = 0; k < 3; k++) begin
            wait_n = 4'(k * 3);
            stack_select = 1'b1;
            b = (k == 0) ? fp : (k == 1) ? sp1 : sb;
            op(5'h10 + 5'(k), 8'h00, 32'h40000000, 32'h05000000, 1'b0, 1);
            chk_ea(ptr(b - 32'd64) + 32'd5);
            cmp_v({29'h0, disp1_len_ff}, 32'd1, "disp1 len");
            cmp_v({29'h0, disp2_len_ff}, 32'd1, "disp2 len");
        end
        wait_n = 4'h0;
    endtask

    task automatic t_direct();
        op(5'h15, 8'h00, 32'hC0FFFFF0, 32'h0, 1'b0, 0);
        chk_ea(32'h00FFFFF0);
        op(5'h15, 8'h00, 32'hFFFFFFFF, 32'h0, 1'b0, 0);
        chk_ea(32'hFFFFFFFF);
        op(5'h13, 8'h00, 32'h0, 32'h0, 1'b0, 0);
        cmp_f(illegal_ff, 1'b1, "reserved");
        op(5'h14, 8'h00, 32'h0, 32'h0, 1'b0, 0);
        cmp_f(imm_sel_ff, 1'b1, "imm sel");
        cmp_v(imm_data_ff, 32'h12345678, "imm data");
        cmp_f(illegal_ff, 1'b0, "imm read ok");
        op(5'h14, 8'h00, 32'h0, 32'h0, 1'b1, 0);
        cmp_f(illegal_ff, 1'b1, "imm write");
        wait_n = 4'h5;
        op(5'h16, 8'h00, 32'h03000000, 32'h08000000, 1'b0, 1);
        chk_ea(ptr(ltb + 32'd12) + 32'd8);
        wait_n = 4'h0;
    endtask

    task automatic t_tos();
        for (int w = 0; w < 2; w++) begin
            stack_select = w[0];
            op(5'h17, 8'h00, 32'h0, 32'h0, w[0], 0);
            cmp_f(sp_upd_ff, 1'b1, "sp upd");
            cmp_f(sp_which_ff, w[0], "sp which");
            cmp_v(sp_new_ff, w[0] ? sp1 - 32'd4 : sp0 + 32'd4, "sp new");
            chk_ea(w[0] ? sp1 - 32'd4 : sp0);
        end
    endtask

    task automatic t_idx();
        for (int s = 0; s < 4; s++) begin
            op({3'b111, 2'(s)}, {5'h0A, 3'd5}, 32'h10000000, 32'h0, 1'b0, 0);
            chk_ea(gr[2] + 32'd16 + (gr[5] << s));
        end
        op(5'h1D, {5'h10, 3'd6}, 32'h40000000, 32'h05000000, 1'b0, 1);
        chk_ea(ptr(fp - 32'd64) + 32'd5 + (gr[6] << 1));
        op(5'h1C, {5'h14, 3'd1}, 32'h0, 32'h0, 1'b0, 0);
        cmp_f(illegal_ff, 1'b1, "index imm");
        op(5'h1C, {5'h1C, 3'd1}, 32'h0, 32'h0, 1'b0, 0);
        cmp_f(illegal_ff, 1'b1, "index nested");
    endtask

    initial begin
        for (int i = 0; i < 8; i++) begin
            gr[i] = 32'h00010000 * (i + 1) + 32'h10;
        end
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        t_reg();
        t_rrel();
        t_mspace();
        t_mrel();
        t_direct();
        t_tos();
        t_idx();
        print_verdict();
    end

    // all scenarios need well under 2000 cycles
    initial begin
        #40000;
        miscompares++;
        print_verdict();
    end
endmodule // operand_address_mode_unit_bench
